// ---- verilog/twarb_pkg.sv ----
`default_nettype none
package twarb_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int          CLK_MHZ  = 200;
  localparam int          HALF_NS  = 5000;
  localparam int          HALF_INT = (HALF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [10:0] HALF_CYC = 11'(HALF_INT);

  // ****************************************
  // frame positions and fields
  // ****************************************
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT  = 4'h8;
  localparam int         CODE_HI  = 7;
  localparam int         CODE_LO  = 3;
  localparam int         PIN_SDA  = 0;
  localparam int         PIN_SCL  = 1;

  // ****************************************
  // status codes
  // ****************************************
  localparam logic [7:0] CODE_IDLE    = 8'hF8;
  localparam logic [7:0] CODE_BUS_ERR = 8'h00;
  localparam logic [7:0] CODE_START   = 8'h08;
  localparam logic [7:0] CODE_RSTART  = 8'h10;
  localparam logic [7:0] CODE_AW_ACK  = 8'h18;
  localparam logic [7:0] CODE_AW_NACK = 8'h20;
  localparam logic [7:0] CODE_DW_ACK  = 8'h28;
  localparam logic [7:0] CODE_DW_NACK = 8'h30;
  localparam logic [7:0] CODE_ARB     = 8'h38;
  localparam logic [7:0] CODE_AR_ACK  = 8'h40;
  localparam logic [7:0] CODE_AR_NACK = 8'h48;
  localparam logic [7:0] CODE_DR_ACK  = 8'h50;
  localparam logic [7:0] CODE_DR_NACK = 8'h58;
  localparam logic [7:0] CODE_OWN_W   = 8'h60;
  localparam logic [7:0] CODE_ARB_W   = 8'h68;
  localparam logic [7:0] CODE_SR_ACK  = 8'h80;
  localparam logic [7:0] CODE_SR_NACK = 8'h88;
  localparam logic [7:0] CODE_OWN_R   = 8'hA8;
  localparam logic [7:0] CODE_ARB_R   = 8'hB0;
  localparam logic [7:0] CODE_ST_ACK  = 8'hB8;
  localparam logic [7:0] CODE_ST_NACK = 8'hC0;
  localparam logic [7:0] STAT_RST     = 8'hF8;

  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_START = 5'h02,
    S_XFER  = 5'h04,
    S_HOLD  = 5'h08,
    S_STOP  = 5'h10
  } twarb_state_e;

  typedef struct packed {
    logic       job_done;
    logic       ack_en;
    logic       start_req;
    logic       stop_req;
    logic       enable;
    logic [1:0] presc;
  } twarb_ctrl_s;

  typedef struct packed {
    logic master;
    logic tx;
    logic addr;
    logic lost;
    logic err;
    logic match;
    logic dir;
    logic ackd;
    logic cont;
  } twarb_xfer_s;

endpackage
`default_nettype wire

// ---- verilog/twarb_top.sv ----
`default_nettype none
module twarb_top (
  input  wire logic                   CLK,
  input  wire logic                   RST_N,
  input  wire logic                   LINK_CLK,
  input  wire logic                   SDA_IN,
  input  wire logic                   SCL_IN,
  output logic                        SDA_OUT,
  output logic                        SDA_OE,
  output logic                        SCL_OUT,
  output logic                        SCL_OE,
  input  wire logic                   CTRL_WR,
  input  wire twarb_pkg::twarb_ctrl_s CTRL_IN,
  input  wire logic                   DATA_WR,
  input  wire logic [7:0]             DATA_IN,
  input  wire logic [6:0]             OWN_ADDR,
  output twarb_pkg::twarb_ctrl_s      CTRL_OUT,
  output logic [7:0]                  STATUS_OUT,
  output logic [7:0]                  DATA_OUT
);

  // ****************************************
  // link domain: bus bits shifted on the bus clock
  // ****************************************
  // system side reads this only after a synchronised rise, while it stands still
  logic [7:0] link_sh_ff;
  logic [7:0] nxt_link_sh;

  always_comb begin
    nxt_link_sh = {link_sh_ff[6:0], SDA_IN};
  end

  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      link_sh_ff <= 8'h00;
    end else begin
      link_sh_ff <= nxt_link_sh;
    end
  end

  // ****************************************
  // pin synchronisers and filter
  // ****************************************
  logic [1:0] pin_in;
  logic [2:0] sy_ff  [2];
  logic [2:0] nxt_sy [2];
  logic [1:0] lvl_ff;
  logic [1:0] nxt_lvl;
  logic [1:0] prv_ff;

  assign pin_in = {SCL_IN, SDA_IN};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_comb begin
        nxt_sy[gi] = {sy_ff[gi][1:0], pin_in[gi]};
      end
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          sy_ff[gi] <= 3'h7;
        end else begin
          sy_ff[gi] <= nxt_sy[gi];
        end
      end
    end
  endgenerate

  // level moves only once stages two and three agree
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      nxt_lvl[i] = (sy_ff[i][1] == sy_ff[i][2]) ? sy_ff[i][2] : lvl_ff[i];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      lvl_ff <= 2'h3;
      prv_ff <= 2'h3;
    end else begin
      lvl_ff <= nxt_lvl;
      prv_ff <= lvl_ff;
    end
  end

  logic scl_hi;
  logic sda_hi;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_hi    = lvl_ff[twarb_pkg::PIN_SCL];
  assign sda_hi    = lvl_ff[twarb_pkg::PIN_SDA];
  assign scl_rise  = scl_hi && !prv_ff[twarb_pkg::PIN_SCL];
  assign scl_fall  = !scl_hi && prv_ff[twarb_pkg::PIN_SCL];
  assign start_det = scl_hi && prv_ff[twarb_pkg::PIN_SCL] && !sda_hi && prv_ff[twarb_pkg::PIN_SDA];
  assign stop_det  = scl_hi && prv_ff[twarb_pkg::PIN_SCL] && sda_hi && !prv_ff[twarb_pkg::PIN_SDA];

  // ****************************************
  // control, transfer engine, status
  // ****************************************
  twarb_pkg::twarb_state_e state_ff;
  twarb_pkg::twarb_state_e nxt_state;
  twarb_pkg::twarb_ctrl_s  ctrl_ff;
  twarb_pkg::twarb_ctrl_s  nxt_ctrl;
  twarb_pkg::twarb_xfer_s  xf_ff;
  twarb_pkg::twarb_xfer_s  nxt_xf;
  logic [1:0]              ph_ff;
  logic [1:0]              nxt_ph;
  logic [10:0]             tmr_ff;
  logic [10:0]             nxt_tmr;
  logic [3:0]              bit_ff;
  logic [3:0]              nxt_bit;
  logic [7:0]              sh_ff;
  logic [7:0]              nxt_sh;
  logic [7:0]              data_ff;
  logic [7:0]              nxt_data;
  logic [7:0]              code_ff;
  logic [7:0]              nxt_code;
  logic [7:0]              stat_ff;
  logic [7:0]              nxt_stat;
  logic                    busy_ff;
  logic                    nxt_busy;
  logic                    sda_oe_ff;
  logic                    nxt_sda_oe;
  logic                    scl_oe_ff;
  logic                    nxt_scl_oe;
  logic                    adv;
  logic                    hold;
  logic                    tmr_done;
  logic                    rise_ff;
  logic                    nxt_rise;

  assign tmr_done = (tmr_ff == 11'h000);

  always_comb begin
    nxt_state  = state_ff;
    nxt_ctrl   = ctrl_ff;
    nxt_xf     = xf_ff;
    nxt_ph     = ph_ff;
    nxt_tmr    = tmr_done ? tmr_ff : tmr_ff - 11'h001;
    nxt_bit    = bit_ff;
    nxt_sh     = sh_ff;
    nxt_data   = data_ff;
    nxt_code   = code_ff;
    nxt_busy   = busy_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_scl_oe = scl_oe_ff;
    adv        = 1'b0;
    hold       = 1'b0;
    // the fall that ends a START carries no bit
    nxt_rise   = start_det ? 1'b0 : (scl_rise ? 1'b1 : (scl_fall ? 1'b0 : rise_ff));
    if (start_det) begin
      nxt_busy = 1'b1;
    end else if (stop_det) begin
      nxt_busy = 1'b0;
    end
    if (CTRL_WR) begin
      nxt_ctrl          = CTRL_IN;
      nxt_ctrl.job_done = ctrl_ff.job_done && !CTRL_IN.job_done;
    end
    if (DATA_WR && ctrl_ff.job_done) begin
      nxt_data = DATA_IN;
    end
    if (!ctrl_ff.enable) begin
      nxt_state     = twarb_pkg::S_IDLE;
      nxt_sda_oe    = 1'b0;
      nxt_scl_oe    = 1'b0;
      nxt_xf.master = 1'b0;
    end else begin
      case (state_ff)
        twarb_pkg::S_IDLE: begin
          nxt_sda_oe    = 1'b0;
          nxt_scl_oe    = 1'b0;
          nxt_xf.master = 1'b0;
          if (start_det) begin
            nxt_state   = twarb_pkg::S_XFER;
            nxt_bit     = 4'h0;
            nxt_xf.addr = 1'b1;
            nxt_xf.tx   = 1'b0;
            nxt_xf.lost = 1'b0;
          end else if (ctrl_ff.start_req && !busy_ff) begin
            nxt_state = twarb_pkg::S_START;
            nxt_ph    = 2'h1;
            nxt_tmr   = twarb_pkg::HALF_CYC;
          end
        end
        twarb_pkg::S_START: begin
          if (start_det && ph_ff != 2'h2) begin
            nxt_state   = twarb_pkg::S_XFER;
            nxt_bit     = 4'h0;
            nxt_xf      = '0;
            nxt_xf.addr = 1'b1;
            nxt_sda_oe  = 1'b0;
          end else if (ph_ff == 2'h0) begin
            nxt_sda_oe = 1'b0;
            if (tmr_done) begin
              nxt_scl_oe = 1'b0;
              nxt_ph     = 2'h1;
              nxt_tmr    = twarb_pkg::HALF_CYC;
            end
          end else if (ph_ff == 2'h1) begin
            if (!scl_hi || !sda_hi) begin
              nxt_tmr = twarb_pkg::HALF_CYC;
            end else if (tmr_done) begin
              nxt_sda_oe = 1'b1;
              nxt_ph     = 2'h2;
              nxt_tmr    = twarb_pkg::HALF_CYC;
            end
          end else if (tmr_done) begin
            nxt_code      = xf_ff.master ? twarb_pkg::CODE_RSTART : twarb_pkg::CODE_START;
            nxt_xf        = '0;
            nxt_xf.master = 1'b1;
            nxt_xf.tx     = 1'b1;
            nxt_xf.addr   = 1'b1;
            nxt_xf.cont   = 1'b1;
            hold          = 1'b1;
          end
        end
        twarb_pkg::S_XFER: begin
          if ((start_det || stop_det) && bit_ff != 4'h0) begin
            nxt_code   = twarb_pkg::CODE_BUS_ERR;
            nxt_xf.err = 1'b1;
            nxt_sda_oe = 1'b0;
            hold       = 1'b1;
          end else if (stop_det) begin
            nxt_state  = twarb_pkg::S_IDLE;
            nxt_sda_oe = 1'b0;
          end else if (start_det) begin
            nxt_bit       = 4'h0;
            nxt_xf.addr   = 1'b1;
            nxt_xf.tx     = 1'b0;
            nxt_xf.master = 1'b0;
            nxt_xf.lost   = 1'b0;
            nxt_sda_oe    = 1'b0;
          end else begin
            if (scl_rise && bit_ff == twarb_pkg::ACK_BIT) begin
              nxt_xf.ackd = !sda_hi;
            end else if (scl_rise) begin
              // equal bits never lose, so identical traffic passes unseen
              if (xf_ff.master && xf_ff.tx && sh_ff[7] && !sda_hi) begin
                nxt_xf.master = 1'b0;
                nxt_xf.tx     = 1'b0;
                nxt_xf.lost   = 1'b1;
                nxt_sda_oe    = 1'b0;
              end
              if (bit_ff == twarb_pkg::LAST_BIT) begin
                nxt_data     = link_sh_ff;
                nxt_xf.dir   = link_sh_ff[0];
                nxt_xf.match = xf_ff.addr && !nxt_xf.master && ctrl_ff.ack_en
                               && (link_sh_ff[7:1] == OWN_ADDR);
              end
            end
            if (xf_ff.master && ph_ff == 2'h0) begin
              if (tmr_done) begin
                nxt_scl_oe = 1'b0;
                nxt_ph     = 2'h1;
                nxt_tmr    = twarb_pkg::HALF_CYC;
              end
            end else if (xf_ff.master) begin
              if (!scl_hi) begin
                nxt_tmr = twarb_pkg::HALF_CYC;
              end else if (tmr_done) begin
                nxt_scl_oe = 1'b1;
                nxt_ph     = 2'h0;
                nxt_tmr    = twarb_pkg::HALF_CYC;
                adv        = 1'b1;
              end
            end else begin
              adv = scl_fall && rise_ff;
            end
          end
          if (adv && bit_ff < twarb_pkg::LAST_BIT) begin
            nxt_bit    = bit_ff + 4'h1;
            nxt_sh     = {sh_ff[6:0], 1'b0};
            nxt_sda_oe = nxt_xf.tx && !sh_ff[6];
          end else if (adv && bit_ff == twarb_pkg::LAST_BIT) begin
            nxt_bit    = twarb_pkg::ACK_BIT;
            nxt_sda_oe = !xf_ff.tx
                         && (xf_ff.addr ? xf_ff.match : (ctrl_ff.ack_en && !xf_ff.lost));
          end else if (adv) begin
            nxt_bit     = 4'h0;
            nxt_sda_oe  = 1'b0;
            nxt_xf.cont = 1'b1;
            nxt_xf.addr = 1'b0;
            nxt_xf.lost = 1'b0;
            hold        = 1'b1;
            if (xf_ff.addr && xf_ff.master) begin
              nxt_xf.tx = !xf_ff.dir;
              if (xf_ff.dir) begin
                nxt_code = xf_ff.ackd ? twarb_pkg::CODE_AR_ACK : twarb_pkg::CODE_AR_NACK;
              end else begin
                nxt_code = xf_ff.ackd ? twarb_pkg::CODE_AW_ACK : twarb_pkg::CODE_AW_NACK;
              end
            end else if (xf_ff.addr && xf_ff.match) begin
              nxt_xf.tx = xf_ff.dir;
              if (xf_ff.dir) begin
                nxt_code = xf_ff.lost ? twarb_pkg::CODE_ARB_R : twarb_pkg::CODE_OWN_R;
              end else begin
                nxt_code = xf_ff.lost ? twarb_pkg::CODE_ARB_W : twarb_pkg::CODE_OWN_W;
              end
            end else if (xf_ff.lost) begin
              nxt_code    = twarb_pkg::CODE_ARB;
              nxt_xf.cont = 1'b0;
            end else if (xf_ff.addr) begin
              hold      = 1'b0;
              nxt_state = twarb_pkg::S_IDLE;
            end else if (xf_ff.master && xf_ff.tx) begin
              nxt_code = xf_ff.ackd ? twarb_pkg::CODE_DW_ACK : twarb_pkg::CODE_DW_NACK;
            end else if (xf_ff.master) begin
              nxt_code = xf_ff.ackd ? twarb_pkg::CODE_DR_ACK : twarb_pkg::CODE_DR_NACK;
            end else if (xf_ff.tx) begin
              nxt_code    = xf_ff.ackd ? twarb_pkg::CODE_ST_ACK : twarb_pkg::CODE_ST_NACK;
              nxt_xf.cont = xf_ff.ackd;
            end else begin
              nxt_code    = xf_ff.ackd ? twarb_pkg::CODE_SR_ACK : twarb_pkg::CODE_SR_NACK;
              nxt_xf.cont = xf_ff.ackd;
            end
          end
        end
        twarb_pkg::S_HOLD: begin
          nxt_scl_oe = 1'b1;
          if (CTRL_WR && CTRL_IN.job_done) begin
            nxt_tmr = twarb_pkg::HALF_CYC;
            nxt_bit = 4'h0;
            nxt_ph  = 2'h0;
            if (xf_ff.err) begin
              nxt_xf            = '0;
              nxt_ctrl.stop_req = 1'b0;
              nxt_sda_oe        = 1'b0;
              nxt_scl_oe        = 1'b0;
              nxt_state         = twarb_pkg::S_IDLE;
            end else if (xf_ff.master && CTRL_IN.stop_req) begin
              nxt_sda_oe = 1'b1;
              nxt_state  = twarb_pkg::S_STOP;
            end else if (xf_ff.master && CTRL_IN.start_req) begin
              nxt_sda_oe = 1'b0;
              nxt_state  = twarb_pkg::S_START;
            end else if (!xf_ff.cont) begin
              nxt_xf     = '0;
              nxt_sda_oe = 1'b0;
              nxt_scl_oe = 1'b0;
              nxt_state  = twarb_pkg::S_IDLE;
            end else begin
              nxt_sh     = nxt_data;
              nxt_sda_oe = xf_ff.tx && !nxt_data[7];
              nxt_scl_oe = xf_ff.master;
              nxt_state  = twarb_pkg::S_XFER;
            end
          end
        end
        twarb_pkg::S_STOP: begin
          if (ph_ff == 2'h0) begin
            if (tmr_done) begin
              nxt_scl_oe = 1'b0;
              nxt_ph     = 2'h1;
              nxt_tmr    = twarb_pkg::HALF_CYC;
            end
          end else if (!scl_hi) begin
            nxt_tmr = twarb_pkg::HALF_CYC;
          end else if (tmr_done) begin
            nxt_sda_oe        = 1'b0;
            nxt_ctrl.stop_req = 1'b0;
            nxt_xf.master     = 1'b0;
            nxt_state         = twarb_pkg::S_IDLE;
          end
        end
        default: begin
          nxt_state = twarb_pkg::S_IDLE;
        end
      endcase
    end
    // hardware set wins over a software clear in the same cycle
    if (hold) begin
      nxt_state         = twarb_pkg::S_HOLD;
      nxt_ctrl.job_done = 1'b1;
      nxt_scl_oe        = 1'b1;
    end
    nxt_stat = {nxt_ctrl.job_done ? nxt_code[twarb_pkg::CODE_HI:twarb_pkg::CODE_LO]
                : twarb_pkg::CODE_IDLE[twarb_pkg::CODE_HI:twarb_pkg::CODE_LO],
                1'b0, nxt_ctrl.presc};
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff  <= twarb_pkg::S_IDLE;
      ctrl_ff   <= '0;
      xf_ff     <= '0;
      ph_ff     <= 2'h0;
      tmr_ff    <= 11'h000;
      bit_ff    <= 4'h0;
      sh_ff     <= 8'h00;
      data_ff   <= 8'h00;
      code_ff   <= twarb_pkg::CODE_IDLE;
      stat_ff   <= twarb_pkg::STAT_RST;
      busy_ff   <= 1'b0;
      sda_oe_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      rise_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      ctrl_ff   <= nxt_ctrl;
      xf_ff     <= nxt_xf;
      ph_ff     <= nxt_ph;
      tmr_ff    <= nxt_tmr;
      bit_ff    <= nxt_bit;
      sh_ff     <= nxt_sh;
      data_ff   <= nxt_data;
      code_ff   <= nxt_code;
      stat_ff   <= nxt_stat;
      busy_ff   <= nxt_busy;
      sda_oe_ff <= nxt_sda_oe;
      scl_oe_ff <= nxt_scl_oe;
      rise_ff   <= nxt_rise;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic drive_lo_ff;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      drive_lo_ff <= 1'b0;
    end else begin
      drive_lo_ff <= 1'b0;
    end
  end

  assign SDA_OUT    = drive_lo_ff;
  assign SCL_OUT    = drive_lo_ff;
  assign SDA_OE     = sda_oe_ff;
  assign SCL_OE     = scl_oe_ff;
  assign CTRL_OUT   = ctrl_ff;
  assign STATUS_OUT = stat_ff;
  assign DATA_OUT   = data_ff;

endmodule
`default_nettype wire

// ---- tb/twarb_chk.sv ----
`default_nettype none
module twarb_chk (
  input wire logic                   CLK,
  input wire logic                   RST_N,
  input wire logic                   SDA_OE,
  input wire logic                   SCL_OE,
  input wire logic                   CTRL_WR,
  input wire twarb_pkg::twarb_ctrl_s CTRL_IN,
  input wire twarb_pkg::twarb_ctrl_s CTRL_OUT,
  input wire logic [7:0]             STATUS_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // recovery write while in bus error
  // ****
  logic rcv;
  assign rcv = CTRL_WR && CTRL_IN.job_done && CTRL_IN.stop_req && !CTRL_IN.start_req
               && CTRL_OUT.job_done && STATUS_OUT[7:3] == 5'h00;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  idle_code_a: assert property (!CTRL_OUT.job_done |-> STATUS_OUT[7:3] == 5'h1F)
    else $error("status not idle while flag clear");
  err_release_a: assert property (STATUS_OUT[7:3] == 5'h00 |-> !SDA_OE && SCL_OE)
    else $error("bus error state drives wrong lines");
  stretch_a: assert property (CTRL_OUT.job_done && CTRL_OUT.enable |-> SCL_OE)
    else $error("clock not held while flag set");
  recover_a: assert property (rcv |=> !CTRL_OUT.job_done && !CTRL_OUT.stop_req
    && STATUS_OUT == {5'h1F, 1'b0, $past(CTRL_IN.presc)}) else $error("recovery state wrong");
  keep_bits_a: assert property (rcv |=> CTRL_OUT.ack_en == $past(CTRL_IN.ack_en)
    && CTRL_OUT.enable == $past(CTRL_IN.enable)) else $error("recovery altered bits");
  line_free_a: assert property (rcv |=> (!SDA_OE && !SCL_OE) [*8])
    else $error("lines driven after recovery");
  presc_field_a: assert property (STATUS_OUT[2:0] == {1'b0, CTRL_OUT.presc})
    else $error("status low bits wrong");
  hold_code_a: assert property (CTRL_OUT.job_done && $past(CTRL_OUT.job_done)
    && !$past(CTRL_WR) |-> $stable(STATUS_OUT)) else $error("status moved while held");
  cover property (rcv);
  cover property (CTRL_OUT.job_done && STATUS_OUT[7:3] == 5'h0C);
  cover property (CTRL_OUT.job_done && STATUS_OUT[7:3] == 5'h02);
endmodule
bind twarb_top twarb_chk i_twarb_chk (.CLK(CLK), .RST_N(RST_N), .SDA_OE(SDA_OE),
  .SCL_OE(SCL_OE), .CTRL_WR(CTRL_WR), .CTRL_IN(CTRL_IN), .CTRL_OUT(CTRL_OUT),
  .STATUS_OUT(STATUS_OUT));
`default_nettype wire

// ---- tb/twarb_far.sv ----
`default_nettype none
module twarb_far (
  input  wire logic sda,
  input  wire logic scl,
  output logic      sda_pull,
  output logic      scl_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] slv_addr;
  logic [7:0] sh;
  logic       slv_on, first, sel, m_sda, ack_pull;
  int         cnt;
  assign sda_pull = m_sda | ack_pull;
  initial begin
    {slv_addr, sh, slv_on, first, sel, m_sda, ack_pull, scl_pull} = '0;
    cnt = 0;
  end
  // ****
  // master side, clock runs only in frames
  // ****
  task automatic hp;
    #62.5;
  endtask
  task automatic start_c;
    m_sda = 1;
    hp;
    scl_pull = 1;
    hp;
  endtask
  task automatic bits(input logic [7:0] d, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      m_sda = ~d[i];
      hp;
      scl_pull = 0;
      wait (scl);
      hp;
      scl_pull = 1;
    end
  endtask
  task automatic stop_c;
    m_sda = 1;
    hp;
    scl_pull = 0;
    wait (scl);
    hp;
    m_sda = 0;
    hp;
  endtask
  task automatic bad_start;
    m_sda = 0;
    hp;
    scl_pull = 0;
    wait (scl);
    hp;
    m_sda = 1;
    hp;
  endtask
  task automatic tidy;
    scl_pull = 1;
    hp;
    stop_c;
  endtask
  task automatic clk9(output logic a);
    m_sda = 0;
    hp;
    scl_pull = 0;
    wait (scl);
    hp;
    a = sda;
    scl_pull = 1;
    hp;
  endtask
  // ****
  // slave side, acks its own address
  // ****
  always @(negedge sda) if (scl) begin
    cnt = 0;
    first = 1;
  end
  always @(posedge scl) if (slv_on) begin
    sh = {sh[6:0], sda};
    cnt++;
  end
  always @(negedge scl) if (slv_on && cnt == 8) begin
    if (first) sel = (sh[7:1] == slv_addr);
    first = 0;
    ack_pull = sel;
  end else if (cnt == 9) begin
    ack_pull = 0;
    cnt = 0;
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk, rst_n, ctrl_wr, data_wr, sda_oe, scl_oe, sda_o, scl_o;
  logic                   far_sda, far_scl, sda, scl, ak, ae;
  twarb_pkg::twarb_ctrl_s ctrl_in, ctrl_out;
  logic [7:0]             data_in, status, data_out, b;
  logic [6:0]             own, ma;
  logic [1:0]             p;
  int                     bad_count, cmp_count, n;
  // pull-ups on both wires
  assign sda = !(sda_oe | far_sda);
  assign scl = !(scl_oe | far_scl);
  always #2.5 clk = ~clk;
  twarb_top i_twarb_top (.CLK(clk), .RST_N(rst_n), .LINK_CLK(scl), .SDA_IN(sda),
    .SCL_IN(scl), .SDA_OUT(sda_o), .SDA_OE(sda_oe), .SCL_OUT(scl_o), .SCL_OE(scl_oe),
    .CTRL_WR(ctrl_wr), .CTRL_IN(ctrl_in), .DATA_WR(data_wr), .DATA_IN(data_in),
    .OWN_ADDR(own), .CTRL_OUT(ctrl_out), .STATUS_OUT(status), .DATA_OUT(data_out));
  twarb_far i_twarb_far (.sda(sda), .scl(scl), .sda_pull(far_sda), .scl_pull(far_scl));
  // ****
  // tasks
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] st(input logic [7:0] code);
    return {code[7:3], 1'b0, p};
  endfunction
  task automatic wr_ctrl(input logic d, input logic a, input logic s, input logic o);
    @(posedge clk);
    #1 ctrl_wr = 1;
    ctrl_in = '{d, a, s, o, 1'b1, p};
    @(posedge clk);
    #1 ctrl_wr = 0;
  endtask
  task automatic wr_data(input logic [7:0] v);
    @(posedge clk);
    #1 data_wr = 1;
    data_in = v;
    @(posedge clk);
    #1 data_wr = 0;
  endtask
  task automatic wait_job;
    int i;
    i = 0;
    @(posedge clk);
    while (ctrl_out.job_done !== 1'b1 && i < 30000) begin
      @(posedge clk);
      i++;
    end
    #1 chk({7'h00, ctrl_out.job_done}, 8'h01);
  endtask
  task automatic conclude;
    $display("compares %0d, errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400us;
    bad_count++;
    conclude;
  end
  // ****
  // main sequence
  // ****
  initial begin
    {clk, rst_n, ctrl_wr, data_wr, ctrl_in, data_in, own, p} = '0;
    bad_count = 0;
    cmp_count = 0;
    void'($urandom(32'hE681));
    repeat (8) @(posedge clk);
    #1 rst_n = 1;
    chk(status, 8'hF8);
    chk({1'b0, ctrl_out}, 8'h00);
    chk({6'h00, sda_o, scl_o}, 8'h00);
    p = 2'($urandom);
    own = 7'($urandom);
    wr_ctrl(0, 1, 0, 0);
    i_twarb_far.start_c();
    i_twarb_far.bits({own, 1'b0}, 8);
    i_twarb_far.clk9(ak);
    chk({7'h00, ak}, 8'h00);
    wait_job;
    chk(status, st(8'h60));
    chk(data_out, {own, 1'b0});
    repeat (20) @(posedge clk);
    chk({6'h00, scl_oe, scl}, 8'h02);
    wr_ctrl(1, 1, 0, 0);
    i_twarb_far.stop_c();
    chk(status, st(8'hF8));
    for (int k = 0; k < 4; k++) begin
      p = 2'($urandom);
      b = 8'($urandom);
      ae = 1'($urandom);
      n = 2 + int'($urandom % 6);
      wr_ctrl(0, ae, 0, 0);
      i_twarb_far.start_c();
      i_twarb_far.bits(b, n);
      if (k[0]) i_twarb_far.bad_start();
      else i_twarb_far.stop_c();
      wait_job;
      chk(status, st(8'h00));
      chk({6'h00, scl_oe, sda_oe}, 8'h02);
      wr_ctrl(1, ae, 0, 1);
      @(posedge clk);
      #1 chk({1'b0, ctrl_out}, {2'b00, ae, 3'b001, p});
      chk({6'h00, scl_oe, sda_oe}, 8'h00);
      chk(status, st(8'hF8));
      if (k[0]) i_twarb_far.tidy();
    end
    ma = own ^ 7'h2A;
    i_twarb_far.slv_addr = ma;
    i_twarb_far.slv_on = 1;
    wr_ctrl(0, 1, 1, 0);
    wait_job;
    chk(status, st(8'h08));
    wr_data({ma, 1'b0});
    wr_ctrl(1, 1, 0, 0);
    wait_job;
    chk(status, st(8'h18));
    chk(data_out, {ma, 1'b0});
    wr_ctrl(1, 1, 1, 0);
    wait_job;
    chk(status, st(8'h10));
    wr_data({ma ^ 7'h01, 1'b1});
    wr_ctrl(1, 1, 0, 0);
    wait_job;
    chk(status, st(8'h48));
    wr_ctrl(1, 1, 0, 1);
    n = 0;
    while (!(ctrl_out.stop_req === 1'b0 && sda === 1'b1) && n < 5000) begin
      @(posedge clk);
      n++;
    end
    #1 chk({5'h00, ctrl_out.stop_req, sda, scl}, 8'h03);
    chk(status, st(8'hF8));
    conclude;
  end
endmodule
`default_nettype wire
